/* File: common/reset_clock_mode_pkg.sv */
// Constants and types of the reset clock-mode configuration block
package reset_clock_mode_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] TICK_OFS = 8'h08;

  // ==========================================================
  // Status fields
  localparam int ST_MODE_POS = 0;
  localparam int ST_RSV_POS = 2;
  localparam int ST_HALVE_POS = 3;
  localparam int ST_DONE_POS = 4;
  localparam int ST_SEL_POS = 5;
  localparam int ST_CPM_POS = 12;
  localparam int ST_CORE_POS = 16;
  localparam int ST_FRAC_POS = 21;

  // ==========================================================
  // Control and tick fields
  localparam int CTRL_UPM_TICK_POS = 0;
  localparam logic [1:0] CTRL_UPM_TICK_RESET = 2'h0;
  localparam int TICK_PHASE_POS = 0;
  localparam int TICK_LAST_POS = 8;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STRAP_SETTLE_CYC = 3;
  localparam int BUS_PERIOD_PS = 700000;
  localparam int BUS_PERIOD_CYC = BUS_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [7:0] PHASE_LAST = 8'(BUS_PERIOD_CYC - 1);
  localparam logic [7:0] T2_INT = 8'(BUS_PERIOD_CYC / 4);
  localparam logic [7:0] T2_2P5 = 8'(BUS_PERIOD_CYC * 3 / 10);
  localparam logic [7:0] T2_3P5 = 8'(BUS_PERIOD_CYC * 4 / 14);
  localparam logic [7:0] T3_POS = 8'(BUS_PERIOD_CYC / 2);

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    MODE_LOCAL = 2'h0,
    MODE_PCI_HOST = 2'h1,
    MODE_PCI_AGENT = 2'h2,
    MODE_RESERVED = 2'h3
  } clock_mode_type;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_LATCH = 2'h1,
    ST_RUN = 2'h3
  } cfg_state_type;

endpackage

/* File: logic/reset_clock_mode_config.sv */
// Power-on clock mode latch, ratio decode and memory controller tick generator
`timescale 1ns/10ps

// Contract
// R1: Mode pins select local, PCI host, agent
// R2: Selector is four word bits, three straps
// R3: Drive both loop factors and divider setting
// R4: Configuration taken only at power-on reset
// R5: Eight basic codes give fixed factor pairs
// R6: Extended codes step core factor per group
// R7: Board asserts config select, drives word bits
// R8: Bus outputs change on rising bus edge
// R9: Four ticks per bus cycle, T1/T3 edges
// R10: Integer ratios give evenly spaced ticks
// R11: Fractional ratios shift second, fourth tick
// R12: Programmable machine ticks; others at rising edge
// R13: PCI modes take bits from general lines
// R14: Halving select doubles PCI division factor
// R15: Unassigned selector codes flagged as reserved
module reset_clock_mode_config
  import reset_clock_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Strap pins
  input wire logic pci_mode_select,
  input wire logic host_agent_select,
  input wire logic pci_clock_halving_select,
  input wire logic [2:0] ratio_strap_pins,
  input wire logic reset_config_select,
  input wire logic [3:0] ratio_selector_upper_bits,
  input wire logic [5:0] local_general_lines,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock configuration
  output logic [1:0] clock_mode,
  output logic [3:0] cpm_factor_x2,
  output logic [4:0] core_factor_x2,
  output logic pci_div_double,
  output logic selector_reserved,
  output logic config_done,
  // Memory controller ticks
  output logic [3:0] mem_tick,
  output logic upm_strobe,
  output logic edge_strobe
);

  // ==========================================================
  // Ratio decode: {reserved, cpm x2, core x2}
  function automatic logic [9:0] ratio_decode(input logic [6:0] sel);
    logic [6:0] idx;
    logic [3:0] cpm2;
    logic [4:0] core2;
    logic rsv;
    begin
      idx = 7'h00;
      cpm2 = 4'h0;
      core2 = 5'h00;
      rsv = 1'b0;
      case (sel)
        // R5: basic 33 MHz pairs
        7'h00: begin cpm2 = 4'h6; core2 = 5'h08; end
        7'h01: begin cpm2 = 4'h6; core2 = 5'h0a; end
        7'h02: begin cpm2 = 4'h8; core2 = 5'h08; end
        7'h03: begin cpm2 = 4'h8; core2 = 5'h0a; end
        // R5: basic 66 MHz pairs
        7'h04: begin cpm2 = 4'h4; core2 = 5'h05; end
        7'h05: begin cpm2 = 4'h4; core2 = 5'h06; end
        7'h06: begin cpm2 = 4'h5; core2 = 5'h05; end
        7'h07: begin cpm2 = 4'h5; core2 = 5'h06; end
        default: begin
          if (sel >= 7'h08 && sel <= 7'h20) begin
            // R6: groups of five, core steps 4 to 8
            idx = sel - 7'h08;
            cpm2 = 4'h4 + 4'(2 * (idx / 7'h05));
            core2 = 5'h08 + 5'(2 * (idx % 7'h05));
          end else begin
            // R15: unassigned code
            rsv = 1'b1;
          end
        end
      endcase
      ratio_decode = {rsv, cpm2, core2};
    end
  endfunction

  // ==========================================================
  // Strap synchronisers
  localparam int SYNC_W = 17;
  logic [SYNC_W-1:0] strap_meta_r;
  logic [SYNC_W-1:0] strap_sync_r;
  logic [SYNC_W-1:0] strap_raw;

  assign strap_raw = {pci_mode_select, host_agent_select, pci_clock_halving_select,
                      ratio_strap_pins, reset_config_select, ratio_selector_upper_bits,
                      local_general_lines};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strap_meta_r <= '0;
      strap_sync_r <= '0;
    end else begin
      strap_meta_r <= strap_raw;
      strap_sync_r <= strap_meta_r;
    end
  end

  logic s_pci_mode;
  logic s_host_agent;
  logic s_halving;
  logic [2:0] s_straps;
  logic s_rcs;
  logic [3:0] s_word;
  logic [5:0] s_lgl;

  assign {s_pci_mode, s_host_agent, s_halving, s_straps, s_rcs, s_word, s_lgl} = strap_sync_r;

  // ==========================================================
  // Mode and selector forming
  clock_mode_type mode_now;
  logic [3:0] upper_now;
  logic halve_now;
  logic [6:0] sel_now;
  logic [9:0] dec_now;

  always_comb begin
    // R1: mode pin decode
    if (s_pci_mode) begin
      mode_now = MODE_LOCAL;
    end else if (!s_host_agent && !s_halving) begin
      mode_now = MODE_PCI_HOST;
    end else if (!s_host_agent && s_halving) begin
      mode_now = MODE_PCI_AGENT;
    end else begin
      mode_now = MODE_RESERVED;
    end
    // R13: PCI modes use general lines
    if (!s_pci_mode) begin
      upper_now = s_lgl[3:0];
      halve_now = s_lgl[5];
    end else begin
      // R7: word bits valid under config select
      upper_now = s_rcs ? s_word : 4'h0;
      halve_now = 1'b0;
    end
  end

  // R2: seven-bit selector
  assign sel_now = {upper_now, s_straps};
  assign dec_now = ratio_decode(sel_now);

  // ==========================================================
  // Power-on latch sequence
  cfg_state_type state_r;
  logic [1:0] settle_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_SETTLE;
      settle_r <= 2'h0;
    end else begin
      // R4: one capture per reset
      case (state_r)
        ST_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == 2'(STRAP_SETTLE_CYC - 1)) begin
            state_r <= ST_LATCH;
          end
        end
        ST_LATCH: state_r <= ST_RUN;
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_SETTLE;
      endcase
    end
  end

  logic [6:0] sel_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clock_mode <= MODE_LOCAL;
      sel_r <= 7'h00;
      cpm_factor_x2 <= 4'h0;
      core_factor_x2 <= 5'h00;
      pci_div_double <= 1'b0;
      selector_reserved <= 1'b0;
      config_done <= 1'b0;
    end else if (state_r == ST_LATCH) begin
      // R3: loop factors and divider
      clock_mode <= mode_now;
      sel_r <= sel_now;
      cpm_factor_x2 <= (mode_now == MODE_RESERVED) ? 4'h0 : dec_now[8:5];
      core_factor_x2 <= (mode_now == MODE_RESERVED) ? 5'h00 : dec_now[4:0];
      // R14: halving doubles PCI divider
      pci_div_double <= halve_now;
      // R15: reserved code or mode
      selector_reserved <= dec_now[9] | (mode_now == MODE_RESERVED);
      config_done <= 1'b1;
    end
  end

  // ==========================================================
  // Tick generator
  logic [7:0] phase_r;
  logic frac_2p5;
  logic frac_3p5;
  logic [7:0] t2_pos;
  logic [7:0] t4_pos;
  logic [3:0] tick_nxt;
  logic [1:0] upm_tick_r;

  assign frac_2p5 = (cpm_factor_x2 == 4'h5);
  assign frac_3p5 = (cpm_factor_x2 == 4'h7);

  always_comb begin
    // R10: even quarter spacing
    t2_pos = T2_INT;
    // R11: fractional spacing
    if (frac_2p5) begin
      t2_pos = T2_2P5;
    end else if (frac_3p5) begin
      t2_pos = T2_3P5;
    end
    t4_pos = T3_POS + t2_pos;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 8'h00;
    end else if (config_done) begin
      phase_r <= (phase_r == PHASE_LAST) ? 8'h00 : phase_r + 8'h01;
    end
  end

  // R9: T1 rising, T3 falling edge
  assign tick_nxt = config_done ? {phase_r == t4_pos, phase_r == T3_POS,
                                   phase_r == t2_pos, phase_r == 8'h00} : 4'h0;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_tick <= 4'h0;
      upm_strobe <= 1'b0;
      edge_strobe <= 1'b0;
    end else begin
      mem_tick <= tick_nxt;
      // R12: programmable machine on chosen tick
      upm_strobe <= tick_nxt[upm_tick_r];
      // R8: bus, SDRAM and chip-select edge
      edge_strobe <= tick_nxt[0];
    end
  end

  // ==========================================================
  // AHB-Lite slave
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic addr_valid;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] tick_word;
  logic [31:0] rd_word;

  assign addr_valid = hsel & hready & htrans[1];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_MODE_POS +: 2] = clock_mode;
    status_word[ST_RSV_POS] = selector_reserved;
    status_word[ST_HALVE_POS] = pci_div_double;
    status_word[ST_DONE_POS] = config_done;
    status_word[ST_SEL_POS +: 7] = sel_r;
    status_word[ST_CPM_POS +: 4] = cpm_factor_x2;
    status_word[ST_CORE_POS +: 5] = core_factor_x2;
    status_word[ST_FRAC_POS] = frac_2p5 | frac_3p5;
    ctrl_word = 32'h0000_0000;
    if (wr_pend_r && wr_addr_r == CTRL_OFS) begin
      ctrl_word[CTRL_UPM_TICK_POS +: 2] = hwdata[CTRL_UPM_TICK_POS +: 2];
    end else begin
      ctrl_word[CTRL_UPM_TICK_POS +: 2] = upm_tick_r;
    end
    tick_word = 32'h0000_0000;
    tick_word[TICK_PHASE_POS +: 8] = phase_r;
    tick_word[TICK_LAST_POS +: 4] = mem_tick;
    case (haddr[7:0])
      STATUS_OFS: rd_word = status_word;
      CTRL_OFS: rd_word = ctrl_word;
      TICK_OFS: rd_word = tick_word;
      default: rd_word = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= addr_valid & hwrite;
      wr_addr_r <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
      if (addr_valid && !hwrite) begin
        hrdata <= rd_word;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upm_tick_r <= CTRL_UPM_TICK_RESET;
    end else if (wr_pend_r && wr_addr_r == CTRL_OFS) begin
      upm_tick_r <= hwdata[CTRL_UPM_TICK_POS +: 2];
    end
  end

endmodule

/* File: dv/rcm_checker.sv */
// Port assertions of the clock-mode block
`timescale 1ns/10ps
module rcm_checker
  import reset_clock_mode_pkg::*;
(
  // Watched ports
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] clock_mode,
  input wire logic [3:0] cpm_factor_x2,
  input wire logic [4:0] core_factor_x2,
  input wire logic pci_div_double,
  input wire logic selector_reserved,
  input wire logic config_done,
  input wire logic [3:0] mem_tick,
  input wire logic upm_strobe,
  input wire logic edge_strobe
);
  // ========
  // Relations
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_hold;
    config_done |=> config_done && $stable(cpm_factor_x2) && $stable(clock_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_quiet; !config_done |-> mem_tick == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("early tick");
  property p_hot; $onehot0(mem_tick); endproperty
  a_hot: assert property (p_hot) else $error("ticks overlap");
  property p_t1; mem_tick[0] |-> ##140 mem_tick[0]; endproperty
  a_t1: assert property (p_t1) else $error("bus period");
  property p_t3; mem_tick[0] |-> ##70 mem_tick[2]; endproperty
  a_t3: assert property (p_t3) else $error("t3 place");
  property p_t2;
    mem_tick[0] && !cpm_factor_x2[0] && !selector_reserved |-> ##35 mem_tick[1];
  endproperty
  a_t2: assert property (p_t2) else $error("t2 even");
  property p_t2f; mem_tick[0] && cpm_factor_x2 == 4'h5 |-> ##42 mem_tick[1]; endproperty
  a_t2f: assert property (p_t2f) else $error("t2 shifted");
  property p_t4; mem_tick[1] |-> ##70 mem_tick[3]; endproperty
  a_t4: assert property (p_t4) else $error("t4 place");
  property p_edge; edge_strobe == mem_tick[0]; endproperty
  a_edge: assert property (p_edge) else $error("edge strobe");
  property p_upm; upm_strobe |-> mem_tick != 4'h0; endproperty
  a_upm: assert property (p_upm) else $error("upm off tick");
  property p_rsv; selector_reserved |-> cpm_factor_x2 == 4'h0 && core_factor_x2 == 5'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved factors");
  property p_loc; clock_mode == MODE_LOCAL |-> !pci_div_double; endproperty
  a_loc: assert property (p_loc) else $error("local halving");
  c_done: cover property ($rose(config_done));
  c_frac: cover property (mem_tick[1] && cpm_factor_x2 == 4'h5);
  c_upm: cover property (upm_strobe && !edge_strobe);
endmodule

/* File: dv/strap_board_model.sv */
// Board strap and reset configuration source
`timescale 1ns/10ps
module strap_board_model (
  // Bench commands
  input wire logic [1:0] mode_req,
  input wire logic [6:0] code,
  input wire logic halve,
  input wire logic use_cfg,
  // Straps
  output logic pci_mode_select,
  output logic host_agent_select,
  output logic pci_clock_halving_select,
  output logic [2:0] ratio_strap_pins,
  output logic reset_config_select,
  output logic [3:0] ratio_selector_upper_bits,
  output logic [5:0] local_general_lines
);
  logic pci;
  // ========
  // Strap drive
  assign pci = mode_req != 2'h0;
  assign pci_mode_select = !pci;
  assign host_agent_select = mode_req == 2'h3;
  assign pci_clock_halving_select = mode_req == 2'h2;
  assign ratio_strap_pins = code[2:0];
  assign reset_config_select = use_cfg;
  assign ratio_selector_upper_bits = pci ? ~code[6:3] : code[6:3];
  assign local_general_lines = pci ? {halve, 1'b0, code[6:3]} : {~halve, 1'b1, ~code[6:3]};
endmodule

/* File: dv/tb.sv */
// Testbench of the clock-mode block
`timescale 1ns/10ps
module tb;
  import reset_clock_mode_pkg::*;
  logic clk_sys, rst_b, hsel, hwrite, hresp, hreadyout, hready, upm_strobe, edge_strobe;
  logic pci_mode_select, host_agent_select, pci_clock_halving_select, reset_config_select;
  logic pci_div_double, selector_reserved, config_done, halve, use_cfg;
  logic [2:0] ratio_strap_pins, hsize;
  logic [3:0] ratio_selector_upper_bits, cpm_factor_x2, mem_tick;
  logic [5:0] local_general_lines;
  logic [1:0] htrans, clock_mode, mode_req;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [4:0] core_factor_x2;
  logic [6:0] code;
  int miscompares, check_count, n, t2;
  assign hready = hreadyout;
  reset_clock_mode_config i_dut (.*);
  strap_board_model i_board (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bail(input logic ok);
    if (!ok) begin
      miscompares++;
      final_report;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    for (n = 0; n < 9; n++) begin @(posedge clk_sys); if (hready === 1'b1) break; end
    bail(n < 9);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    for (n = 0; n < 9; n++) begin @(posedge clk_sys); if (hready === 1'b1) break; end
    bail(n < 9);
    q = hrdata;
  endtask
  task automatic cfg(input logic [1:0] m, input logic [6:0] c, input logic h, u);
    @(posedge clk_sys);
    mode_req <= m; code <= c; halve <= h; use_cfg <= u; rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (n = 0; n < 20 && config_done !== 1'b1; n++) @(posedge clk_sys);
    bail(n < 20);
  endtask
  function automatic logic [8:0] fac(input logic [6:0] s);
    if (s > 7'h20) return 9'h0;
    if (s < 7'h08) return s[2] ? {4'(4 + s[1]), 5'(5 + s[0])} : {4'(6 + 2 * s[1]), 5'(8 + 2 * s[0])};
    return {4'(4 + 2 * ((s - 8) / 5)), 5'(8 + 2 * ((s - 8) % 5))};
  endfunction
  task automatic expect_cfg(input logic [1:0] m, input logic [6:0] s, input logic h);
    logic r;
    logic p;
    logic [8:0] f;
    r = m == 2'h3 || s > 7'h20;
    p = h && m != 2'h0;
    f = r ? 9'h0 : fac(s);
    chk("mode", clock_mode, m);
    chk("cpm", cpm_factor_x2, f[8:5]);
    chk("core", core_factor_x2, f[4:0]);
    chk("reserved", selector_reserved, r);
    if (!r) begin
      chk("halving", pci_div_double, p);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("status", q, {10'h0, f[5], f[4:0], f[8:5], s, 1'b1, p, 1'b0, m});
    end
  endtask
  task automatic gap(input int k, input int e);
    @(negedge clk_sys);
    for (n = 0; n < 300 && edge_strobe !== 1'b1; n++) @(negedge clk_sys);
    bail(n < 300);
    for (n = 0; n < 300 && mem_tick[k] !== 1'b1; n++) @(negedge clk_sys);
    chk("tick gap", n, e);
  endtask
  // ========
  // Sequence
  initial begin
    miscompares = 0; check_count = 0; rst_b = 1'b0; hsel = 1'b0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
    mode_req = 2'h0; code = 7'h0; halve = 1'b0; use_cfg = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int s = 0; s < 36; s++) begin
      cfg(2'h0, 7'(s), 1'b1, 1'b1);
      expect_cfg(2'h0, 7'(s), 1'b0);
    end
    cfg(2'h0, 7'h7d, 1'b0, 1'b0);
    expect_cfg(2'h0, 7'h05, 1'b0);
    $display("selector sweep done");
    for (int m = 1; m < 4; m++) begin
      cfg(2'(m), 7'h0a, 1'b1, 1'b1);
      expect_cfg(2'(m), 7'h0a, 1'b1);
      cfg(2'(m), 7'h0a, 1'b0, 1'b1);
      expect_cfg(2'(m), 7'h0a, 1'b0);
    end
    $display("pci modes done");
    cfg(2'h0, 7'h0c, 1'b0, 1'b1);
    code <= 7'h7f;
    mode_req <= 2'h1;
    repeat (8) @(posedge clk_sys);
    bus(1'b1, STATUS_OFS, 32'hffffffff);
    expect_cfg(2'h0, 7'h0c, 1'b0);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("resp", hresp, 1'b0);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", q, 32'(CTRL_UPM_TICK_RESET));
    $display("registers done");
    for (int c = 6; c < 8; c++) begin
      cfg(2'h0, 7'(c * 6 % 12), 1'b0, 1'b1);
      t2 = c == 6 ? BUS_PERIOD_CYC / 4 : BUS_PERIOD_CYC * 3 / 10;
      gap(1, t2);
      gap(2, BUS_PERIOD_CYC / 2);
      gap(3, t2 + BUS_PERIOD_CYC / 2);
      bus(1'b0, TICK_OFS, 32'h0);
      chk("tick word", q, 32'(t2 + BUS_PERIOD_CYC / 2 + 2));
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, CTRL_OFS, 32'(k));
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", q, 32'(k));
        @(negedge clk_sys);
        for (n = 0; n < 300 && mem_tick[k] !== 1'b1; n++) @(negedge clk_sys);
        chk("upm strobe", upm_strobe, 1'b1);
      end
    end
    $display("ticks done");
    final_report;
  end
endmodule
bind reset_clock_mode_config rcm_checker i_chk (.*);
